// ### shared/spm_pkg.sv
package spm_pkg;

  // ---------------------------------------------------------------------------
  // Data and bit counting
  // ---------------------------------------------------------------------------
  localparam int            BYTE_W    = 8;
  localparam int            BIT_CNT_W = 3;
  localparam logic [2:0]    BIT_FIRST = 3'h0;
  localparam logic [2:0]    BIT_LAST  = 3'h7;
  localparam logic [7:0]    DATA_RST  = 8'h00;

  // ---------------------------------------------------------------------------
  // Serial clock timing in link clock cycles
  // ---------------------------------------------------------------------------
  // Each half of the serial clock lasts HALF_CYC link cycles.
  localparam int            HALF_CYC  = 2;
  localparam int            HALF_W    = 2;
  localparam logic [1:0]    HALF_ZERO = 2'h0;
  localparam logic [1:0]    HALF_LAST = 2'(HALF_CYC - 1);

  // ---------------------------------------------------------------------------
  // Configuration bundle carried into the link domain
  // ---------------------------------------------------------------------------
  localparam int            CFG_W     = 7;
  localparam int            CFG_EN    = 0;
  localparam int            CFG_HDX   = 1;
  localparam int            CFG_DIR   = 2;
  localparam int            CFG_POL   = 3;
  localparam int            CFG_TPH   = 4;
  localparam int            CFG_RPH   = 5;
  localparam int            CFG_LSB   = 6;
  localparam logic [6:0]    CFG_RST   = 7'h00;

  // ---------------------------------------------------------------------------
  // Shifter states
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    SPM_IDLE  = 3'b001,
    SPM_LEAD  = 3'b010,
    SPM_TRAIL = 3'b100
  } spm_shift_e;

  // Position in the byte of serial bit number k for the chosen bit order.
  function automatic logic [2:0] spm_bit_index(input logic lsb, input logic [2:0] k);
    return lsb ? k : 3'(BIT_LAST - k);
  endfunction

endpackage

// ### design/spm_sync.sv
`timescale 1ns/1ps

// Two flip-flop synchroniser for levels entering the clk_i domain given here.
module spm_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] q_next;

  // The first stage feeds the second stage and nothing else.
  always_comb begin
    meta_next = d_i;
    q_next    = meta_reg;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_reg <= '0;
      q_o      <= '0;
    end else begin
      meta_reg <= meta_next;
      q_o      <= q_next;
    end
  end

endmodule

// ### design/spm_master.sv
// Notes on behaviour
// - Nothing shifts and no serial clock runs until the enable bit is set.
// - Duplex select at 1 gives half duplex on one shared data line.
// - Duplex select at 0 gives full duplex with separate out and in lines.
// - In half duplex, direction 0 receives from the slave, 1 drives out.
// - Receive direction disables the output buffer; input still sampled each clock.
// - Polarity, transmit phase and receive phase bits set the serial clocking.
// - Bit order control at 0 shifts the most significant bit first.
// - Writing transmit data clears the transmit-empty flag.
// - With shifter empty, a written byte loads, re-sets transmit-empty, starts clocking.
// - A byte written while shifting waits until the current byte completes.
// - After 8 clock pulses, byte ends, receive-full sets, interrupt raises if enabled.
// - At byte end any pending byte loads, sets transmit-empty, starts next byte.
// - Input sampled on every serial clock; received byte stored at byte end.
// - Transmit-empty set means ready for the next byte, transmit or receive.
`timescale 1ns/1ps

module spm_master
  import spm_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        link_clk_i,
  input  wire logic        block_enable_i,
  input  wire logic        duplex_select_i,
  input  wire logic        bidir_output_enable_i,
  input  wire logic        clock_polarity_i,
  input  wire logic        tx_clock_phase_i,
  input  wire logic        rx_clock_phase_i,
  input  wire logic        lsb_first_select_i,
  input  wire logic        irq_enable_i,
  input  wire logic        tx_wr_i,
  input  wire logic [7:0]  tx_wdata_i,
  input  wire logic        rx_rd_i,
  input  wire logic        serial_data_in_i,
  input  wire logic        serial_data_line_i,
  output logic             tx_empty_flag_o,
  output logic             rx_full_flag_o,
  output logic      [7:0]  rx_data_o,
  output logic             serial_irq_o,
  output logic             busy_o,
  output logic             sclk_o,
  output logic             serial_data_out_o,
  output logic             serial_data_oe_n_o
);

  // ---------------------------------------------------------------------------
  // Controller domain state
  // ---------------------------------------------------------------------------
  logic [CFG_W-1:0]  cfg_reg;
  logic [CFG_W-1:0]  cfg_next;
  logic [7:0]        tx_data_reg;
  logic [7:0]        tx_data_next;
  logic [7:0]        shift_data_reg;
  logic [7:0]        shift_data_next;
  logic              tx_empty_next;
  logic              rx_full_next;
  logic [7:0]        rx_data_next;
  logic              irq_next;
  logic              busy_next;
  logic              start_tgl_reg;
  logic              start_tgl_next;
  logic              done_seen_reg;
  logic              done_seen_next;
  logic              done_sync;
  logic              done_evt;
  logic              load_evt;

  // ---------------------------------------------------------------------------
  // Link domain state
  // ---------------------------------------------------------------------------
  logic              link_rst_meta_reg;
  logic              link_rst_reg;
  logic [CFG_W-1:0]  cfg_sync;
  logic              start_sync;
  logic [1:0]        pin_sync;
  spm_shift_e        state_reg;
  spm_shift_e        state_next;
  logic [HALF_W-1:0] half_reg;
  logic [HALF_W-1:0] half_next;
  logic [2:0]        bit_reg;
  logic [2:0]        bit_next;
  logic [7:0]        txs_reg;
  logic [7:0]        txs_next;
  logic [7:0]        rxs_reg;
  logic [7:0]        rxs_next;
  logic [7:0]        rx_byte_reg;
  logic [7:0]        rx_byte_next;
  logic              start_seen_reg;
  logic              start_seen_next;
  logic              done_tgl_reg;
  logic              done_tgl_next;
  logic              sclk_next;
  logic              dout_next;
  logic              oe_n_next;
  logic              din_bit;
  logic              start_evt;

  // ---------------------------------------------------------------------------
  // Crossings
  // ---------------------------------------------------------------------------
  // Configuration is taken from registered copies so that no combinational
  // glitch reaches the link domain; the bits are treated as quasi-static.
  spm_sync #(.WIDTH(CFG_W + 1)) u_cfg_sync (
    .clk_i (link_clk_i),
    .rst_i (link_rst_reg),
    .d_i   ({start_tgl_reg, cfg_reg}),
    .q_o   ({start_sync, cfg_sync})
  );

  // Both data pins come from outside and pass two flip-flops first.
  spm_sync #(.WIDTH(2)) u_pin_sync (
    .clk_i (link_clk_i),
    .rst_i (link_rst_reg),
    .d_i   ({serial_data_line_i, serial_data_in_i}),
    .q_o   (pin_sync)
  );

  // Byte completion returns as a toggle; the received byte is held stable
  // in the link domain until the next start, so it is safe to copy here.
  spm_sync #(.WIDTH(1)) u_done_sync (
    .clk_i (clk_i),
    .rst_i (sys_rst_i),
    .d_i   (done_tgl_reg),
    .q_o   (done_sync)
  );

  // Link reset asserts at once and releases on the link clock.
  always_ff @(posedge link_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      link_rst_meta_reg <= 1'b1;
      link_rst_reg      <= 1'b1;
    end else begin
      link_rst_meta_reg <= 1'b0;
      link_rst_reg      <= link_rst_meta_reg;
    end
  end

  // ---------------------------------------------------------------------------
  // Controller side: holding register, flags and interrupt
  // ---------------------------------------------------------------------------
  assign done_evt = done_sync ^ done_seen_reg;
  // A byte can load when the shifter is free or finishes in this very cycle.
  assign load_evt = cfg_reg[CFG_EN] && !tx_empty_flag_o
                    && (!busy_o || done_evt);

  always_comb begin
    cfg_next        = {lsb_first_select_i, rx_clock_phase_i, tx_clock_phase_i,
                       clock_polarity_i, bidir_output_enable_i, duplex_select_i,
                       block_enable_i};
    tx_data_next    = tx_data_reg;
    shift_data_next = shift_data_reg;
    tx_empty_next   = tx_empty_flag_o;
    rx_full_next    = rx_full_flag_o;
    rx_data_next    = rx_data_o;
    busy_next       = busy_o;
    start_tgl_next  = start_tgl_reg;
    done_seen_next  = done_sync;
    // Firmware read clears receive-full; a completion in the same cycle wins.
    if (rx_rd_i) begin
      rx_full_next = 1'b0;
    end
    if (done_evt) begin
      rx_data_next = rx_byte_reg;
      rx_full_next = 1'b1;
      busy_next    = 1'b0;
    end
    // The pending byte moves into the shifter and the holding slot frees up.
    if (load_evt) begin
      shift_data_next = tx_data_reg;
      start_tgl_next  = ~start_tgl_reg;
      busy_next       = 1'b1;
      tx_empty_next   = 1'b1;
    end
    // A write is taken while the holding slot is free or empties in this cycle; any other write to a full
    // slot is dropped rather than overwrite the byte already promised.
    if (tx_wr_i && tx_empty_flag_o) begin
      tx_data_next  = tx_wdata_i;
      tx_empty_next = 1'b0;
    end else if (tx_wr_i && load_evt) begin
      tx_data_next  = tx_wdata_i;
      tx_empty_next = 1'b0;
    end
    // Disabling abandons a byte in flight so the block cannot hang busy.
    if (!cfg_reg[CFG_EN]) begin
      busy_next = 1'b0;
    end
    irq_next = rx_full_next && irq_enable_i;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cfg_reg         <= CFG_RST;
      tx_data_reg     <= DATA_RST;
      shift_data_reg  <= DATA_RST;
      tx_empty_flag_o <= 1'b1;
      rx_full_flag_o  <= 1'b0;
      rx_data_o       <= DATA_RST;
      serial_irq_o    <= 1'b0;
      busy_o          <= 1'b0;
      start_tgl_reg   <= 1'b0;
      done_seen_reg   <= 1'b0;
    end else begin
      cfg_reg         <= cfg_next;
      tx_data_reg     <= tx_data_next;
      shift_data_reg  <= shift_data_next;
      tx_empty_flag_o <= tx_empty_next;
      rx_full_flag_o  <= rx_full_next;
      rx_data_o       <= rx_data_next;
      serial_irq_o    <= irq_next;
      busy_o          <= busy_next;
      start_tgl_reg   <= start_tgl_next;
      done_seen_reg   <= done_seen_next;
    end
  end

  // ---------------------------------------------------------------------------
  // Link side: serial clock, shifting and sampling
  // ---------------------------------------------------------------------------
  assign start_evt = start_sync ^ start_seen_reg;
  // Half duplex samples the shared line, full duplex the separate input.
  assign din_bit   = cfg_sync[CFG_HDX] ? pin_sync[1] : pin_sync[0];

  always_comb begin
    state_next      = state_reg;
    half_next       = half_reg;
    bit_next        = bit_reg;
    txs_next        = txs_reg;
    rxs_next        = rxs_reg;
    rx_byte_next    = rx_byte_reg;
    start_seen_next = start_sync;
    done_tgl_next   = done_tgl_reg;
    sclk_next       = cfg_sync[CFG_POL];
    dout_next       = serial_data_out_o;
    // Output buffer on only while enabled: in full duplex always, in half duplex only when transmitting.
    oe_n_next       = ~(cfg_sync[CFG_EN] &&
                        (!cfg_sync[CFG_HDX] || cfg_sync[CFG_DIR]));
    case (state_reg)
      SPM_IDLE: begin
        if (start_evt && cfg_sync[CFG_EN]) begin
          txs_next   = shift_data_reg;
          bit_next   = BIT_FIRST;
          half_next  = HALF_ZERO;
          state_next = SPM_LEAD;
          if (!cfg_sync[CFG_TPH]) begin
            dout_next = shift_data_reg[spm_bit_index(cfg_sync[CFG_LSB], BIT_FIRST)];
          end
        end
      end
      SPM_LEAD: begin
        half_next = 2'(half_reg + 2'h1);
        if (half_reg == HALF_LAST) begin
          // Leading edge of the serial clock.
          half_next  = HALF_ZERO;
          sclk_next  = ~cfg_sync[CFG_POL];
          state_next = SPM_TRAIL;
          if (!cfg_sync[CFG_RPH]) begin
            rxs_next[spm_bit_index(cfg_sync[CFG_LSB], bit_reg)] = din_bit;
          end
          if (cfg_sync[CFG_TPH]) begin
            dout_next = txs_reg[spm_bit_index(cfg_sync[CFG_LSB], bit_reg)];
          end
        end
      end
      SPM_TRAIL: begin
        sclk_next = ~cfg_sync[CFG_POL];
        half_next = 2'(half_reg + 2'h1);
        if (half_reg == HALF_LAST) begin
          // Trailing edge of the serial clock.
          half_next = HALF_ZERO;
          sclk_next = cfg_sync[CFG_POL];
          if (cfg_sync[CFG_RPH]) begin
            rxs_next[spm_bit_index(cfg_sync[CFG_LSB], bit_reg)] = din_bit;
          end
          if (bit_reg == BIT_LAST) begin
            // Eighth pulse done: hand the byte back and go quiet.
            rx_byte_next  = rxs_next;
            done_tgl_next = ~done_tgl_reg;
            state_next    = SPM_IDLE;
          end else begin
            bit_next   = 3'(bit_reg + 3'h1);
            state_next = SPM_LEAD;
            if (!cfg_sync[CFG_TPH]) begin
              dout_next = txs_reg[spm_bit_index(cfg_sync[CFG_LSB], 3'(bit_reg + 3'h1))];
            end
          end
        end
      end
      default: begin
        state_next = SPM_IDLE;
      end
    endcase
    // Disable aborts quietly, with the clock parked at its idle level.
    if (!cfg_sync[CFG_EN]) begin
      state_next = SPM_IDLE;
      sclk_next  = cfg_sync[CFG_POL];
    end
  end

  always_ff @(posedge link_clk_i or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      state_reg          <= SPM_IDLE;
      half_reg           <= HALF_ZERO;
      bit_reg            <= BIT_FIRST;
      txs_reg            <= DATA_RST;
      rxs_reg            <= DATA_RST;
      rx_byte_reg        <= DATA_RST;
      start_seen_reg     <= 1'b0;
      done_tgl_reg       <= 1'b0;
      sclk_o             <= 1'b0;
      serial_data_out_o  <= 1'b0;
      serial_data_oe_n_o <= 1'b1;
    end else begin
      state_reg          <= state_next;
      half_reg           <= half_next;
      bit_reg            <= bit_next;
      txs_reg            <= txs_next;
      rxs_reg            <= rxs_next;
      rx_byte_reg        <= rx_byte_next;
      start_seen_reg     <= start_seen_next;
      done_tgl_reg       <= done_tgl_next;
      sclk_o             <= sclk_next;
      serial_data_out_o  <= dout_next;
      serial_data_oe_n_o <= oe_n_next;
    end
  end

endmodule

// ### tb/spm_assertions.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Port checks for the serial master
// ----------------------------------------------------------------
module spm_assertions (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic link_clk_i,
  input wire logic block_enable_i,
  input wire logic duplex_select_i,
  input wire logic bidir_output_enable_i,
  input wire logic clock_polarity_i,
  input wire logic tx_wr_i,
  input wire logic rx_rd_i,
  input wire logic tx_empty_flag_o,
  input wire logic rx_full_flag_o,
  input wire logic busy_o,
  input wire logic sclk_o,
  input wire logic serial_data_oe_n_o
);
  logic [3:0] pulse_reg;
  logic [3:0] pulse_next;
  logic       sclk_d_reg;
  logic       full_d_reg;

  // Leading edges of the current byte; cleared when a byte completes.
  always_comb begin
    pulse_next = pulse_reg;
    if (rx_full_flag_o && !full_d_reg) begin
      pulse_next = 4'h0;
    end else if (sclk_o != clock_polarity_i && sclk_d_reg == clock_polarity_i) begin
      pulse_next = pulse_reg + 4'h1;
    end
  end

  // The serial clock is far slower than clk_i, so no edge slips past.
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pulse_reg  <= 4'h0;
      sclk_d_reg <= 1'b0;
      full_d_reg <= 1'b0;
    end else begin
      pulse_reg  <= pulse_next;
      sclk_d_reg <= sclk_o;
      full_d_reg <= rx_full_flag_o;
    end
  end

  sequence s_write_idle;
    tx_wr_i && tx_empty_flag_o && !busy_o && block_enable_i && $past(block_enable_i, 4);
  endsequence

  sequence s_rx_only;
    (block_enable_i && duplex_select_i && !bidir_output_enable_i) [*8];
  endsequence

  tx_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    tx_wr_i && tx_empty_flag_o |=> !tx_empty_flag_o) else $error("tx empty stayed set");
  load_start_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    s_write_idle |=> ##1 (tx_empty_flag_o && busy_o)) else $error("idle load missing");
  pend_wait_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    busy_o && !tx_empty_flag_o && block_enable_i |=>
    tx_empty_flag_o == $rose(rx_full_flag_o)) else $error("pending byte moved early");
  pend_load_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(rx_full_flag_o) && !$past(tx_empty_flag_o) |-> tx_empty_flag_o && busy_o)
    else $error("pending byte not loaded");
  byte_pulses_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    $rose(rx_full_flag_o) |-> pulse_reg == 4'h8) else $error("byte without 8 pulses");
  read_clear_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    rx_rd_i && !busy_o |=> !rx_full_flag_o) else $error("read left rx full set");
  off_quiet_a: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    (!block_enable_i) [*8] |-> $stable(sclk_o) && serial_data_oe_n_o)
    else $error("activity while disabled");
  hdx_rx_off_a: assert property (@(posedge link_clk_i) disable iff (sys_rst_i)
    s_rx_only |-> serial_data_oe_n_o) else $error("driving in receive direction");
endmodule

bind spm_master spm_assertions u_chk (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .link_clk_i(link_clk_i),
  .block_enable_i(block_enable_i), .duplex_select_i(duplex_select_i),
  .bidir_output_enable_i(bidir_output_enable_i), .clock_polarity_i(clock_polarity_i),
  .tx_wr_i(tx_wr_i), .rx_rd_i(rx_rd_i), .tx_empty_flag_o(tx_empty_flag_o),
  .rx_full_flag_o(rx_full_flag_o), .busy_o(busy_o), .sclk_o(sclk_o),
  .serial_data_oe_n_o(serial_data_oe_n_o)
);

// ### tb/spm_slave_model.sv
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Serial slave: samples on the leading edge, then shifts at once
// ----------------------------------------------------------------
module spm_slave_model (
  input  wire logic       sclk_i,
  input  wire logic       cs_n_i,
  input  wire logic       pol_i,
  input  wire logic       mosi_i,
  input  wire logic [7:0] tx_byte_i,
  output logic            miso_o,
  output logic      [7:0] rx_byte_o
);
  logic [7:0] out_sr = 8'hFF;
  logic [7:0] in_sr  = 8'h00;
  int         nbits  = 0;

  // Selecting the slave puts the first reply bit on the line almost at once.
  // The short wait lets a reply byte set in the same step as the select land.
  always @(negedge cs_n_i) begin
    #1;
    out_sr = tx_byte_i;
    nbits  = 0;
  end

  // The master reads its input through two link flip-flops, so it needs each
  // reply bit a half clock ahead; the next bit goes out right after sampling.
  // A new reply byte is taken at the leading edge that completes a byte.
  always @(sclk_i) begin
    if (!cs_n_i && sclk_i != pol_i) begin
      in_sr = {in_sr[6:0], mosi_i};
      nbits = nbits + 1;
      if (nbits == 8) begin
        rx_byte_o = in_sr;
        nbits     = 0;
        out_sr    = tx_byte_i;
      end else begin
        out_sr = {out_sr[6:0], 1'b1};
      end
    end
  end

  assign miso_o = out_sr[7];
endmodule

// ### tb/tb_spi_master_half_duplex_transfer.sv
`timescale 1ns/1ps

module tb_spi_master_half_duplex_transfer;
  logic       clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       en = 1'b0;
  logic       hdx = 1'b0;
  logic       dir = 1'b0;
  logic       pol = 1'b0;
  logic       lsb = 1'b0;
  logic       irq_en = 1'b1;
  logic       tx_wr = 1'b0;
  logic [7:0] tx_wdata = 8'h00;
  logic       rx_rd = 1'b0;
  logic       cs_n = 1'b1;
  logic       talk = 1'b1;
  logic [7:0] sl_tx = 8'h00;
  wire        tx_empty, rx_full, irq, busy, sclk, dout, oe_n, miso;
  wire  [7:0] rx_data;
  wire  [7:0] sl_rx;
  int         n_fail = 0;
  int         checked = 0;

  // Released lines float high through the board pull-ups.
  wire line = !oe_n ? dout : ((talk && !cs_n) ? miso : 1'b1);
  wire din  = !cs_n ? miso : 1'b1;
  wire mosi = hdx ? line : dout;

  // Two unrelated clocks; the link clock is phase shifted on purpose.
  initial forever #5 clk = ~clk;
  initial begin
    #1;
    forever begin
      link_clk = ~link_clk;
      #15;
    end
  end

  spm_master u_dut (
    .clk_i(clk), .sys_rst_i(sys_rst), .link_clk_i(link_clk), .block_enable_i(en),
    .duplex_select_i(hdx), .bidir_output_enable_i(dir), .clock_polarity_i(pol),
    .tx_clock_phase_i(1'b0), .rx_clock_phase_i(1'b0), .lsb_first_select_i(lsb),
    .irq_enable_i(irq_en), .tx_wr_i(tx_wr), .tx_wdata_i(tx_wdata), .rx_rd_i(rx_rd),
    .serial_data_in_i(din), .serial_data_line_i(line), .tx_empty_flag_o(tx_empty),
    .rx_full_flag_o(rx_full), .rx_data_o(rx_data), .serial_irq_o(irq), .busy_o(busy),
    .sclk_o(sclk), .serial_data_out_o(dout), .serial_data_oe_n_o(oe_n)
  );

  spm_slave_model u_slave (
    .sclk_i(sclk), .cs_n_i(cs_n), .pol_i(pol), .mosi_i(mosi), .tx_byte_i(sl_tx),
    .miso_o(miso), .rx_byte_o(sl_rx)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic report_and_stop;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // A write ends one cycle after the strobe drops so that flags have settled.
  task automatic put_byte(input logic [7:0] d);
    @(negedge clk);
    tx_wdata = d;
    tx_wr    = 1'b1;
    @(negedge clk);
    tx_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic wait_flag(input bit full);
    for (int i = 0; i < 400; i++) begin
      if ((full ? rx_full : tx_empty) === 1'b1) break;
      @(negedge clk);
    end
    if ((full ? rx_full : tx_empty) !== 1'b1) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  // Waits for a byte, judges it, then reads it out as firmware would.
  task automatic take_byte(input logic [7:0] exp, input bit judge);
    wait_flag(1'b1);
    if (judge) check(rx_data, exp);
    check(irq, irq_en);
    @(negedge clk);
    rx_rd = 1'b1;
    @(negedge clk);
    rx_rd = 1'b0;
    check({rx_full, irq}, 8'h00);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_enable_gate;
    check({tx_empty, rx_full, irq, busy, oe_n, sclk}, 8'h22);
    cs_n  = 1'b0;
    sl_tx = 8'h3C;
    put_byte(8'hA5);
    check(tx_empty, 1'b0);
    repeat (60) @(negedge clk);
    check({busy, sclk, oe_n}, 8'h01);
    en = 1'b1;
    take_byte(8'h3C, 1'b1);
    check(sl_rx, 8'hA5);
    cs_n = 1'b1;
  endtask

  task automatic t_half_duplex;
    hdx = 1'b1;
    repeat (20) @(negedge clk);
    cs_n  = 1'b0;
    sl_tx = 8'h5A;
    put_byte(8'hFF);
    check(busy, 1'b1);
    wait_flag(1'b0);
    put_byte(8'hEE);
    check({busy, tx_empty}, 8'h02);
    put_byte(8'h11);
    sl_tx = 8'hC3;
    take_byte(8'h5A, 1'b1);
    check(sl_rx, 8'h5A);
    take_byte(8'hC3, 1'b1);
    check(busy, 1'b0);
    talk = 1'b0;
    dir  = 1'b1;
    repeat (20) @(negedge clk);
    put_byte(8'h96);
    wait_flag(1'b0);
    put_byte(8'h69);
    take_byte(8'h00, 1'b0);
    check(sl_rx, 8'h96);
    take_byte(8'h00, 1'b0);
    check(sl_rx, 8'h69);
    cs_n = 1'b1;
  endtask

  // Reversed bit order and inverted clock, with the interrupt masked.
  task automatic t_pol_lsb;
    {hdx, dir, talk, pol, lsb, irq_en} = 6'b001110;
    repeat (30) @(negedge clk);
    check(sclk, 1'b1);
    cs_n  = 1'b0;
    sl_tx = 8'h1E;
    put_byte(8'hB4);
    take_byte(8'h78, 1'b1);
    check(sl_rx, 8'h2D);
    cs_n = 1'b1;
    {pol, lsb} = 2'b00;
    repeat (30) @(negedge clk);
    check(sclk, 1'b0);
    en = 1'b0;
    repeat (30) @(negedge clk);
    check(oe_n, 1'b1);
  endtask

  // Main sequence: reset for four cycles, then the scenarios in turn.
  initial begin
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge clk);
    t_enable_gate();
    t_half_duplex();
    t_pol_lsb();
    report_and_stop();
  end
endmodule
